// ---- verilog/can_modes_wakeup_bit_timing.sv ----
// mode control, sleep handshake, wake-up, timestamp pulse and
// bit timing of a CAN controller.
// assumes the protocol engine, buffers and filters sit outside;
// ticks and cpu states come from logic on core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module can_modes_wakeup_bit_timing
  import can_modes_pkg::*;
#(
  parameter int CTRL_ID = 0,
  parameter int WAKE_FILTER_CYCLES = WAKE_FILTER_CYC
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_stop_i,
  input wire logic cpu_wait_i,
  input wire logic crystal_osc_tick_i,
  input wire logic system_clock_tick_i,
  input wire logic bus_rx_in_i,
  output logic bus_tx_out_o,
  input wire logic engine_tx_i,
  input wire logic tx_pending_i,
  input wire logic rx_active_i,
  input wire logic frame_ok_i,
  input wire logic bus_off_i,
  input wire err_evt_t err_evt_i,
  output mode_t mode_o,
  output logic engine_run_o,
  output logic engine_stop_o,
  output logic tq_tick_o,
  output logic sample_pulse_o,
  output logic sample_bit_o,
  output logic busoff_done_o,
  output logic wake_flag_o,
  output logic timestamp_o,
  output logic capture_ch4_o,
  output logic capture_ch5_o,
  output logic [7:0] filter_control_o,
  output logic [63:0] filter_pattern_o,
  output logic [63:0] filter_mask_o
);

  // ==========================================================
  // registers and declarations
  logic slp_req_ff;
  logic slp_ack_ff;
  logic wake_filt_ff;
  logic ts_link_ff;
  logic stop_wait_ff;
  logic sreset_ff;
  logic clk_src_ff;
  logic [1:0] sjw_ff;
  logic [5:0] presc_ff;
  logic [2:0] second_segment_len_ff;
  logic [3:0] first_segment_len_ff;
  logic [7:0] fctrl_ff;
  logic [7:0] pattern_ff [8];
  logic [7:0] mask_ff [8];
  logic wake_flag_ff;
  logic wake_ie_ff;
  logic [7:0] rx_err_ff;
  logic [7:0] tx_err_ff;
  logic [7:0] rdata_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  logic [15:0] wake_cnt_ff;
  logic joined_ff;
  logic [5:0] presc_cnt_ff;
  logic [4:0] tq_pos_ff;
  logic [2:0] ext_ff;
  logic [3:0] run_ff;
  logic [7:0] grp_ff;
  logic tq_tick_ff;
  logic sample_ff;
  logic sample_bit_ff;
  logic busoff_done_ff;
  logic ts_ff;
  logic tx_ff;

  mode_t mode;
  logic pwr_down;
  logic clk_run;
  logic access_ok;
  logic wr_ok;
  logic cfg_wr_ok;
  logic bus_wake;
  logic proto_tick;
  logic tq_tick;
  logic [4:0] seg1_end;
  logic [4:0] bit_end;
  logic [4:0] sjw_q;
  logic rx_edge;
  logic at_sample;
  logic at_bit_end;
  logic grp_tick;
  logic [3:0] first_segment_len_w;
  logic [2:0] second_segment_len_w;
  logic [7:0] rd_val;

  // ==========================================================
  // mode decode
  always_comb
  begin
    pwr_down = cpu_stop_i | (cpu_wait_i & stop_wait_ff);
    if (pwr_down)
      mode = MODE_POWER_DOWN;
    else if (slp_ack_ff && !sreset_ff)
      mode = MODE_SLEEP;
    else if (sreset_ff)
      mode = MODE_SOFT_RESET;
    else
      mode = MODE_NORMAL;
  end

  // timing runs only in normal mode
  assign clk_run = (mode == MODE_NORMAL);
  assign access_ok = !pwr_down;
  assign wr_ok = wr_i & access_ok;
  assign cfg_wr_ok = wr_ok & sreset_ff;

  // ==========================================================
  // receive pin synchroniser and wake-up detect
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= bus_rx_in_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  // glitch filter: dominant must persist before waking
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      wake_cnt_ff <= '0;
    else if (mode != MODE_SLEEP || rx_sync_ff)
      wake_cnt_ff <= '0;
    else if (!bus_wake)
      wake_cnt_ff <= wake_cnt_ff + 16'h0001;
  end

  always_comb
  begin
    bus_wake = 1'b0;
    if (mode == MODE_SLEEP && !rx_sync_ff)
    begin
      if (wake_filt_ff)
        bus_wake = (32'(wake_cnt_ff) >= WAKE_FILTER_CYCLES - 1);
      else
        bus_wake = 1'b1;
    end
  end

  // ==========================================================
  // module control zero: sleep handshake and mode bits
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      slp_req_ff <= 1'b0;
      wake_filt_ff <= 1'b0;
      ts_link_ff <= 1'b0;
      stop_wait_ff <= 1'b0;
      sreset_ff <= SRESET_RESET;
    end
    else
    begin
      if (wr_ok && addr_i == OFS_CTRL0)
      begin
        wake_filt_ff <= wdata_i[CTRL0_WAKE_FILT];
        ts_link_ff <= wdata_i[CTRL0_TS_LINK];
        stop_wait_ff <= wdata_i[CTRL0_STOP_WAIT];
        sreset_ff <= wdata_i[CTRL0_SRESET];
        if (wdata_i[CTRL0_SLP_REQ] || slp_ack_ff)
          slp_req_ff <= wdata_i[CTRL0_SLP_REQ];
      end
      if (bus_wake)
        slp_req_ff <= 1'b0;
    end
  end

  // acknowledge tracks sleep itself
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      slp_ack_ff <= 1'b0;
    else if (sreset_ff || pwr_down)
      slp_ack_ff <= slp_ack_ff & !sreset_ff;
    else if (slp_ack_ff)
      slp_ack_ff <= slp_req_ff & !bus_wake;
    else
      slp_ack_ff <= slp_req_ff & !tx_pending_i & !rx_active_i;
  end

  // ==========================================================
  // configuration registers, writable only under soft reset
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_src_ff <= 1'b0;
      sjw_ff <= '0;
      presc_ff <= '0;
      second_segment_len_ff <= SECOND_SEGMENT_LEN_MIN;
      first_segment_len_ff <= FIRST_SEGMENT_LEN_MIN;
      fctrl_ff <= '0;
    end
    else if (cfg_wr_ok)
    begin
      unique case (addr_i)
        OFS_CTRL1: clk_src_ff <= wdata_i[CTRL1_CLK_SRC];
        OFS_BT0:
        begin
          sjw_ff <= wdata_i[7:6];
          presc_ff <= wdata_i[5:0];
        end
        OFS_BT1:
        begin
          second_segment_len_ff <= second_segment_len_w;
          first_segment_len_ff <= first_segment_len_w;
        end
        OFS_FCTRL: fctrl_ff <= wdata_i;
        default: ;
      endcase
    end
  end

  // segment fields below the legal range saturate to the minimum
  assign first_segment_len_w = (wdata_i[3:0] < FIRST_SEGMENT_LEN_MIN) ? FIRST_SEGMENT_LEN_MIN
                                              : wdata_i[3:0];
  assign second_segment_len_w = (wdata_i[6:4] < SECOND_SEGMENT_LEN_MIN) ? SECOND_SEGMENT_LEN_MIN
                                              : wdata_i[6:4];

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_filter
      always_ff @(posedge core_clk_i)
      begin
        if (!rst_n_i)
        begin
          pattern_ff[i] <= '0;
          mask_ff[i] <= '0;
        end
        else if (cfg_wr_ok && addr_i[2:0] == 3'(i))
        begin
          if (addr_i[5:3] == BANK_PATTERN)
            pattern_ff[i] <= wdata_i;
          if (addr_i[5:3] == BANK_MASK)
            mask_ff[i] <= wdata_i;
        end
      end
      assign filter_pattern_o[i*8 +: 8] = pattern_ff[i];
      assign filter_mask_o[i*8 +: 8] = mask_ff[i];
    end
  endgenerate

  // ==========================================================
  // wake-up flag, write one to clear, new event wins
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wake_flag_ff <= 1'b0;
      wake_ie_ff <= 1'b0;
    end
    else
    begin
      if (wr_ok && addr_i == OFS_FLAGS)
        wake_ie_ff <= wdata_i[FLAGS_WAKE_IE];
      if (bus_wake && slp_ack_ff && wake_ie_ff)
        wake_flag_ff <= 1'b1;
      else if (wr_ok && addr_i == OFS_FLAGS && wdata_i[FLAGS_WAKE])
        wake_flag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // error counters: no write path exists
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || busoff_done_ff)
    begin
      rx_err_ff <= '0;
      tx_err_ff <= '0;
    end
    else if (clk_run)
    begin
      if (err_evt_i.rx_inc8)
        rx_err_ff <= (rx_err_ff > 8'hF7) ? 8'hFF : rx_err_ff + 8'h08;
      else if (err_evt_i.rx_inc && rx_err_ff != 8'hFF)
        rx_err_ff <= rx_err_ff + 8'h01;
      else if (err_evt_i.rx_dec && rx_err_ff != 8'h00)
        rx_err_ff <= rx_err_ff - 8'h01;
      if (err_evt_i.tx_inc8)
        tx_err_ff <= (tx_err_ff > 8'hF7) ? 8'hFF : tx_err_ff + 8'h08;
      else if (err_evt_i.tx_dec && tx_err_ff != 8'h00)
        tx_err_ff <= tx_err_ff - 8'h01;
    end
  end

  // ==========================================================
  // prescaler and bit timing
  assign proto_tick = clk_src_ff ? system_clock_tick_i
                                 : crystal_osc_tick_i;
  assign tq_tick = clk_run & proto_tick & (presc_cnt_ff == presc_ff);
  assign sjw_q = {3'b000, sjw_ff} + 5'h01;
  assign seg1_end = {1'b0, first_segment_len_ff} + 5'h01 + {2'b00, ext_ff};
  assign bit_end = seg1_end + {2'b00, second_segment_len_ff} + 5'h01;
  assign rx_edge = rx_prev_ff & !rx_sync_ff;
  assign at_sample = tq_tick & (tq_pos_ff == seg1_end);
  assign at_bit_end = tq_tick & (tq_pos_ff == bit_end);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      presc_cnt_ff <= '0;
    else if (tq_tick)
      presc_cnt_ff <= '0;
    else if (clk_run && proto_tick)
      presc_cnt_ff <= presc_cnt_ff + 6'h01;
  end

  // position 0 is the sync segment, one quantum long
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      tq_pos_ff <= '0;
      ext_ff <= '0;
    end
    else if (tq_tick)
    begin
      if (rx_edge && !joined_ff)
      begin
        tq_pos_ff <= 5'h01; // hard sync while off the bus
        ext_ff <= '0;
      end
      else if (rx_edge && tq_pos_ff != 5'h00 && tq_pos_ff <= seg1_end)
      begin
        // late edge: stretch first segment
        tq_pos_ff <= tq_pos_ff + 5'h01;
        ext_ff <= (tq_pos_ff < sjw_q) ? tq_pos_ff[2:0]
                                      : sjw_q[2:0];
      end
      else if (rx_edge && tq_pos_ff > seg1_end)
      begin
        // early edge: shorten second segment
        if (bit_end - tq_pos_ff < sjw_q)
          tq_pos_ff <= 5'h01;
        else
          tq_pos_ff <= tq_pos_ff + sjw_q;
        ext_ff <= '0;
      end
      else if (at_bit_end)
      begin
        tq_pos_ff <= '0;
        ext_ff <= '0;
      end
      else
        tq_pos_ff <= tq_pos_ff + 5'h01;
    end
  end

  // ==========================================================
  // recessive runs: rejoin and bus-off recovery
  assign grp_tick = at_sample & rx_sync_ff & (run_ff == RECESSIVE_RUN - 4'h1);

  always_ff @(posedge core_clk_i)
  begin
    // partial group restarts after low power, so rejoin sees 11 fresh bits
    if (!rst_n_i || !clk_run)
      run_ff <= '0;
    else if (at_sample)
      run_ff <= (!rx_sync_ff || grp_tick) ? 4'h0 : run_ff + 4'h1;
  end

  // dropped on any mode change away from normal
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !clk_run)
      joined_ff <= 1'b0;
    else if (grp_tick)
      joined_ff <= 1'b1;
  end

  // count holds during sleep because samples stop
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !bus_off_i)
    begin
      grp_ff <= '0;
      busoff_done_ff <= 1'b0;
    end
    else
    begin
      busoff_done_ff <= 1'b0;
      if (grp_tick)
      begin
        if (grp_ff == BUSOFF_GROUPS - 8'h01)
        begin
          grp_ff <= '0;
          busoff_done_ff <= 1'b1;
        end
        else
          grp_ff <= grp_ff + 8'h01;
      end
    end
  end

  // ==========================================================
  // timestamp pulse: engine flags frame end at a bit boundary
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ts_ff <= 1'b0;
    else if (frame_ok_i && engine_run_o)
      ts_ff <= 1'b1;
    else if (at_bit_end || !clk_run)
      ts_ff <= 1'b0;
  end

  // ==========================================================
  // pin output and status flops
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_ff <= 1'b1;
      tq_tick_ff <= 1'b0;
      sample_ff <= 1'b0;
      sample_bit_ff <= 1'b1;
    end
    else
    begin
      unique case (mode)
        MODE_NORMAL: tx_ff <= joined_ff ? engine_tx_i : 1'b1;
        MODE_SLEEP,
        MODE_SOFT_RESET,
        MODE_POWER_DOWN: tx_ff <= 1'b1;
      endcase
      tq_tick_ff <= tq_tick;
      sample_ff <= at_sample;
      if (at_sample)
        sample_bit_ff <= rx_sync_ff;
    end
  end

  // ==========================================================
  // register read, data valid the cycle after the strobe
  always_comb
  begin
    rd_val = 8'h00;
    if (addr_i[5:3] == BANK_PATTERN)
      rd_val = pattern_ff[addr_i[2:0]];
    else if (addr_i[5:3] == BANK_MASK)
      rd_val = mask_ff[addr_i[2:0]];
    else
    begin
      case (addr_i)
        OFS_CTRL0:
        begin
          rd_val[CTRL0_SLP_REQ] = slp_req_ff;
          rd_val[CTRL0_SLP_ACK] = slp_ack_ff;
          rd_val[CTRL0_WAKE_FILT] = wake_filt_ff;
          rd_val[CTRL0_TS_LINK] = ts_link_ff;
          rd_val[CTRL0_STOP_WAIT] = stop_wait_ff;
          rd_val[CTRL0_SRESET] = sreset_ff;
        end
        OFS_CTRL1: rd_val[CTRL1_CLK_SRC] = clk_src_ff;
        OFS_BT0: rd_val = {sjw_ff, presc_ff};
        OFS_BT1: rd_val = {1'b0, second_segment_len_ff, first_segment_len_ff};
        OFS_FLAGS:
        begin
          rd_val[FLAGS_WAKE] = wake_flag_ff;
          rd_val[FLAGS_WAKE_IE] = wake_ie_ff;
        end
        OFS_FCTRL: rd_val = fctrl_ff;
        OFS_RXERR: rd_val = rx_err_ff;
        OFS_TXERR: rd_val = tx_err_ff;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      rdata_ff <= '0;
    else
      rdata_ff <= (rd_i && access_ok) ? rd_val : 8'h00;
  end

  // ==========================================================
  // outputs
  assign rdata_o = rdata_ff;
  assign bus_tx_out_o = tx_ff;
  assign mode_o = mode;
  assign engine_run_o = clk_run & joined_ff;
  assign engine_stop_o = sreset_ff | pwr_down;
  assign tq_tick_o = tq_tick_ff;
  assign sample_pulse_o = sample_ff;
  assign sample_bit_o = sample_bit_ff;
  assign busoff_done_o = busoff_done_ff;
  assign wake_flag_o = wake_flag_ff;
  assign timestamp_o = ts_ff;
  assign capture_ch4_o = ts_ff & ts_link_ff & (CTRL_ID == 0);
  assign capture_ch5_o = ts_ff & ts_link_ff & (CTRL_ID == 1);
  assign filter_control_o = fctrl_ff;

endmodule : can_modes_wakeup_bit_timing

`default_nettype wire

// ---- verilog/can_modes_pkg.sv ----
// constants, register map and carrier types for the CAN mode,
// wake-up and bit timing block.
// assumes one 25 MHz core clock and an external protocol engine.

package can_modes_pkg;

  // ==========================================================
  // register map (byte registers, 6-bit address)
  localparam logic [5:0] OFS_CTRL0 = 6'h00;
  localparam logic [5:0] OFS_CTRL1 = 6'h01;
  localparam logic [5:0] OFS_BT0 = 6'h02;
  localparam logic [5:0] OFS_BT1 = 6'h03;
  localparam logic [5:0] OFS_FLAGS = 6'h04;
  localparam logic [5:0] OFS_FCTRL = 6'h05;
  localparam logic [5:0] OFS_RXERR = 6'h0E;
  localparam logic [5:0] OFS_TXERR = 6'h0F;
  localparam logic [2:0] BANK_PATTERN = 3'h2;
  localparam logic [2:0] BANK_MASK = 3'h3;

  // ==========================================================
  // field positions
  localparam int CTRL0_SLP_REQ = 0;
  localparam int CTRL0_SLP_ACK = 1;
  localparam int CTRL0_WAKE_FILT = 2;
  localparam int CTRL0_TS_LINK = 3;
  localparam int CTRL0_STOP_WAIT = 5;
  localparam int CTRL0_SRESET = 7;
  localparam int CTRL1_CLK_SRC = 0;
  localparam int FLAGS_WAKE = 0;
  localparam int FLAGS_WAKE_IE = 4;

  // ==========================================================
  // reset values and limits
  localparam logic SRESET_RESET = 1'b1;
  localparam logic [3:0] FIRST_SEGMENT_LEN_MIN = 4'h3;
  localparam logic [2:0] SECOND_SEGMENT_LEN_MIN = 3'h1;
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam logic [7:0] BUSOFF_GROUPS = 8'h80;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_FILTER_NS = 2000;
  localparam int WAKE_FILTER_CYC =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_SOFT_RESET,
    MODE_POWER_DOWN
  } mode_t;

  // protocol engine error counter events
  typedef struct packed {
    logic rx_inc;
    logic rx_inc8;
    logic rx_dec;
    logic tx_inc8;
    logic tx_dec;
  } err_evt_t;

endpackage : can_modes_pkg

// ---- sim/can_modes_checker.sv ----
// assertions on the mode, pin, read and timestamp ports.
// assumes it is bound to the top design module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module can_modes_checker
  import can_modes_pkg::*;
#(
  parameter int CTRL_ID = 0
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic cpu_stop_i,
  input wire logic tx_pending_i,
  input wire logic rx_active_i,
  input wire logic frame_ok_i,
  input wire logic bus_tx_out_o,
  input wire mode_t mode_o,
  input wire logic engine_run_o,
  input wire logic engine_stop_o,
  input wire logic tq_tick_o,
  input wire logic timestamp_o,
  input wire logic capture_ch4_o,
  input wire logic capture_ch5_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ======================================================
  // modes and pins
  AST_TX_RECESSIVE: assert property (
    (mode_o != MODE_NORMAL)[*2] |-> bus_tx_out_o)
    else $error("tx pin not recessive in low power mode");
  AST_CPU_STOP: assert property (
    cpu_stop_i |-> mode_o == MODE_POWER_DOWN)
    else $error("cpu stop without power-down");
  AST_STOP_TRAFFIC: assert property (
    mode_o inside {MODE_SOFT_RESET, MODE_POWER_DOWN} |-> engine_stop_o)
    else $error("traffic not stopped");
  AST_NO_RUN: assert property (
    mode_o != MODE_NORMAL |-> !engine_run_o)
    else $error("engine runs outside normal mode");
  AST_READ_PD: assert property (
    rd_i && cpu_stop_i |=> rdata_o == 8'h00)
    else $error("register read in power-down");
  AST_TQ_STOP: assert property (
    (mode_o == MODE_POWER_DOWN)[*2] |-> !tq_tick_o)
    else $error("quantum tick in power-down");
  AST_SLEEP_WAIT: assert property (
    mode_o == MODE_NORMAL && (tx_pending_i || rx_active_i)
      |=> mode_o != MODE_SLEEP)
    else $error("sleep entered while busy");
  // ======================================================
  // timestamp link
  AST_TS_START: assert property (
    frame_ok_i && engine_run_o |=> timestamp_o)
    else $error("no timestamp after valid frame");
  AST_CAP4: assert property (
    capture_ch4_o |-> timestamp_o && CTRL_ID == 0)
    else $error("wrong capture channel 4 drive");
  AST_CAP5: assert property (
    capture_ch5_o |-> timestamp_o && CTRL_ID == 1)
    else $error("wrong capture channel 5 drive");
endmodule : can_modes_checker
bind can_modes_wakeup_bit_timing can_modes_checker #(.CTRL_ID(CTRL_ID)) chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cpu_stop_i(cpu_stop_i),
  .tx_pending_i(tx_pending_i), .rx_active_i(rx_active_i),
  .frame_ok_i(frame_ok_i), .bus_tx_out_o(bus_tx_out_o),
  .mode_o(mode_o), .engine_run_o(engine_run_o),
  .engine_stop_o(engine_stop_o), .tq_tick_o(tq_tick_o),
  .timestamp_o(timestamp_o), .capture_ch4_o(capture_ch4_o),
  .capture_ch5_o(capture_ch5_o)
);
`default_nettype wire

// ---- sim/can_bus_partner.sv ----
// the CAN bus seen through a transceiver, with one other node.
// assumes the bench calls pull_dominant to make bus activity.
`timescale 1ns/1ps
`default_nettype none
module can_bus_partner (
  input wire logic core_clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  logic node_dom_ff;
  // ======================================================
  // wired-and bus: released bus floats recessive, dominant wins
  assign rx_o = tx_i & ~node_dom_ff;
  initial node_dom_ff = 1'b0;
  // other node sends a dominant burst of n cycles
  task automatic pull_dominant(input int n);
    @(posedge core_clk_i);
    node_dom_ff <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    node_dom_ff <= 1'b0;
  endtask : pull_dominant
endmodule : can_bus_partner
`default_nettype wire

// ---- sim/can_modes_wakeup_bit_timing_test.sv ----
// self-checking bench for the mode, wake-up and timing block.
// assumes the bus partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("mismatch %s exp %h got %h", nm, ex, got); \
    end \
  end
module can_modes_wakeup_bit_timing_test;
  import can_modes_pkg::*;
  logic clk, rst_n, wr, rd, cpu_stop, cpu_wait, osc_tick, sys_tick;
  logic rx_line, tx_line, engine_tx, tx_pending, rx_active, frame_ok;
  logic engine_run, engine_stop, timestamp, cap4, cap5, wake_flag;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, fctrl;
  logic [63:0] fpat, fmask;
  err_evt_t err_evt;
  mode_t mode;
  int errors, samples_checked, seed;
  logic [5:0] tab_a [6] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h10, 6'h18};
  logic [7:0] tab_m [6] = '{8'h01, 8'hC0, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] tab_o [6] = '{8'h00, 8'h00, 8'h13, 8'h00, 8'h00, 8'h00};
  logic [7:0] shadow [6];
  function automatic logic [7:0] cfg_val(input int i, input logic [7:0] r);
    return (r & tab_m[i]) | tab_o[i];
  endfunction : cfg_val
  can_modes_wakeup_bit_timing #(.CTRL_ID(0), .WAKE_FILTER_CYCLES(2)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cpu_stop_i(cpu_stop),
    .cpu_wait_i(cpu_wait), .crystal_osc_tick_i(osc_tick),
    .system_clock_tick_i(sys_tick), .bus_rx_in_i(rx_line),
    .bus_tx_out_o(tx_line), .engine_tx_i(engine_tx),
    .tx_pending_i(tx_pending), .rx_active_i(rx_active),
    .frame_ok_i(frame_ok), .bus_off_i(1'b0), .err_evt_i(err_evt),
    .mode_o(mode), .engine_run_o(engine_run), .engine_stop_o(engine_stop),
    .tq_tick_o(), .sample_pulse_o(), .sample_bit_o(), .busoff_done_o(),
    .wake_flag_o(wake_flag), .timestamp_o(timestamp),
    .capture_ch4_o(cap4), .capture_ch5_o(cap5), .filter_control_o(fctrl),
    .filter_pattern_o(fpat), .filter_mask_o(fmask)
  );
  can_bus_partner bus (.core_clk_i(clk), .tx_i(tx_line), .rx_o(rx_line));
  // ======================================================
  // clock, free-running ticks, watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    osc_tick <= ~osc_tick;
    sys_tick <= 1'($random(seed));
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
  // ======================================================
  // register bus tasks
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] ex,
                        input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask : rd_chk
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ======================================================
  // main sequence
  initial
  begin
    {rst_n, wr, rd, cpu_stop, cpu_wait, osc_tick, sys_tick} = '0;
    {tx_pending, rx_active, frame_ok} = '0;
    engine_tx = 1'b1;
    err_evt = '0;
    addr = '0;
    wdata = '0;
    seed = 33037;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("mode", MODE_SOFT_RESET, mode)
    `CHK("stop", 1'b1, engine_stop)
    `CHK("tx", 1'b1, tx_line)
    rd_chk(OFS_CTRL0, 8'h80, "ctrl0");
    wr_reg(OFS_BT1, 8'h00);
    rd_chk(OFS_BT1, {1'b0, SECOND_SEGMENT_LEN_MIN, FIRST_SEGMENT_LEN_MIN}, "bt1 floor");
    // prescaler kept 0 so rejoin stays short
    for (int i = 0; i < 6; i++)
    begin
      shadow[i] = cfg_val(i, 8'($random(seed)));
      wr_reg(tab_a[i], shadow[i]);
    end
    for (int i = 0; i < 6; i++)
      rd_chk(tab_a[i], shadow[i], "config");
    `CHK("fctrl", shadow[3], fctrl)
    `CHK("fpat", shadow[4], fpat[7:0])
    `CHK("fmask", shadow[5], fmask[7:0])
    wr_reg(OFS_CTRL0, 8'h08);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(tab_a[i], ~shadow[i]);
      rd_chk(tab_a[i], shadow[i], "locked");
    end
    wr_reg(OFS_RXERR, 8'hA5);
    rd_chk(OFS_RXERR, 8'h00, "rxerr");
    @(posedge clk);
    err_evt.rx_inc8 <= 1'b1;
    @(posedge clk);
    err_evt.rx_inc8 <= 1'b0;
    rd_chk(OFS_RXERR, 8'h08, "rxerr evt");
    rd_chk(6'h3F, 8'h00, "unmapped");
    repeat (3000) if (engine_run !== 1'b1) @(posedge clk);
    #1;
    `CHK("run", 1'b1, engine_run)
    `CHK("mode", MODE_NORMAL, mode)
    @(posedge clk);
    frame_ok <= 1'b1;
    @(posedge clk);
    frame_ok <= 1'b0;
    #1;
    `CHK("cap4", 1'b1, cap4)
    `CHK("cap5", 1'b0, cap5)
    @(posedge clk);
    cpu_wait <= 1'b1;
    engine_tx <= 1'b0;
    #1;
    `CHK("mode", MODE_NORMAL, mode)
    wr_reg(OFS_CTRL0, 8'h28);
    #1;
    `CHK("mode", MODE_POWER_DOWN, mode)
    // pin is registered, recessive from the next edge on
    @(posedge clk);
    #1;
    `CHK("tx", 1'b1, tx_line)
    @(posedge clk);
    cpu_wait <= 1'b0;
    cpu_stop <= 1'b1;
    rd_chk(OFS_CTRL0, 8'h00, "pd read");
    @(posedge clk);
    cpu_stop <= 1'b0;
    engine_tx <= 1'b1;
    wr_reg(OFS_CTRL0, 8'h08);
    // sleep held off by reception, early clear refused
    rx_active <= 1'b1;
    wr_reg(OFS_CTRL0, 8'h09);
    rd_chk(OFS_CTRL0, 8'h09, "ack early");
    wr_reg(OFS_CTRL0, 8'h08);
    rd_chk(OFS_CTRL0, 8'h09, "req clear");
    rx_active <= 1'b0;
    rd_chk(OFS_CTRL0, 8'h0B, "ack");
    `CHK("mode", MODE_SLEEP, mode)
    `CHK("tx", 1'b1, tx_line)
    wr_reg(OFS_FLAGS, 8'h10);
    bus.pull_dominant(6);
    repeat (6) @(posedge clk);
    rd_chk(OFS_CTRL0, 8'h08, "bus wake");
    `CHK("wake", 1'b1, wake_flag)
    wr_reg(OFS_FLAGS, 8'h11);
    rd_chk(OFS_FLAGS, 8'h10, "w1c");
    // gap between scheduling and sleep request
    tx_pending <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(OFS_CTRL0, 8'h0D);
    rd_chk(OFS_CTRL0, 8'h0D, "tx busy");
    tx_pending <= 1'b0;
    rd_chk(OFS_CTRL0, 8'h0F, "tx done");
    // one-cycle glitch must not pass the wake filter
    bus.pull_dominant(1);
    repeat (4) @(posedge clk);
    rd_chk(OFS_CTRL0, 8'h0F, "glitch");
    wr_reg(OFS_CTRL0, 8'h0C);
    rd_chk(OFS_CTRL0, 8'h0C, "sw wake");
    `CHK("mode", MODE_NORMAL, mode)
    wr_reg(OFS_CTRL0, 8'h0D);
    bus.pull_dominant(6);
    repeat (6) @(posedge clk);
    rd_chk(OFS_CTRL0, 8'h0C, "filt wake");
    print_verdict();
  end
endmodule : can_modes_wakeup_bit_timing_test
`default_nettype wire
